// ===== logic/i2cbc_pkg.sv
// Shared constants and types of the bus-condition and addressing block
package i2cbc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int LONG_HOLD_NS = 300;
  localparam int SHORT_HOLD_NS = 100;
  localparam int SCL_HALF_NS = 5000;
  localparam logic [3:0] LONG_HOLD_CYC = 4'(((LONG_HOLD_NS * CLK_MHZ) + 999) / 1000);
  localparam logic [3:0] SHORT_HOLD_CYC = 4'(((SHORT_HOLD_NS * CLK_MHZ) + 999) / 1000);
  localparam logic [11:0] SCL_HALF_CYC = 12'((SCL_HALF_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] SYNC_LAT = 12'h004;

  // ----------------------------------------
  // Byte framing and addressing
  // ----------------------------------------
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_ADDR_LO = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

  // ----------------------------------------
  // Commands and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_STOP = 2'b01,
    OP_WRITE = 2'b10,
    OP_READ = 2'b11
  } i2cbc_op_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START_A = 3'b001,
    M_START_B = 3'b010,
    M_LOW = 3'b011,
    M_HIGH = 3'b100,
    M_STOP_A = 3'b101,
    M_STOP_B = 3'b110,
    M_STOP_C = 3'b111
  } i2cbc_mst_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RECV = 2'b01,
    S_TX = 2'b10,
    S_WAIT = 2'b11
  } i2cbc_slv_e;

endpackage

// ===== logic/i2cbc_cond_if.sv
// Bus-condition events carried from the link domain to the system domain
`timescale 1ns/1ns
interface i2cbc_cond_if;
  logic start_t;
  logic stop_t;
  logic rise_t;
  logic fall_t;
  logic rise_sda;
  logic busy;
  modport det (output start_t, output stop_t, output rise_t, output fall_t,
               output rise_sda, output busy);
  modport sink (input start_t, input stop_t, input rise_t, input fall_t,
                input rise_sda, input busy);
endinterface

// ===== logic/i2cbc_evt_sync.sv
// Two-flop level synchroniser with toggle-to-pulse output
`timescale 1ns/1ns
module i2cbc_evt_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic level,
  output logic pulse
);
  logic s1;
  logic s2;
  logic s3;

  // Sync chain; only s2 and s3 are looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign level = s2;
  assign pulse = s2 ^ s3;
endmodule

// ===== logic/i2cbc_cond_det.sv
// Link-clock Start/Stop/edge detector for the two-wire bus
`timescale 1ns/1ns
module i2cbc_cond_det
  import i2cbc_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  i2cbc_cond_if.det cond
);
  logic sc1, sc2, sd1, sd2, scp, sdp;
  logic low_seen, busy, pend, rsda;
  logic start_t, stop_t, rise_t, fall_t;
  logic next_low_seen, next_busy, next_pend, next_rsda;
  logic next_start_t, next_stop_t, next_rise_t, next_fall_t;
  logic is_start, is_stop, is_rise, is_fall;

  // Conditions from successive samples
  always_comb begin
    is_start = scp & sc2 & sdp & ~sd2;
    is_stop = scp & sc2 & ~sdp & sd2 & low_seen;
    is_rise = ~scp & sc2;
    is_fall = scp & ~sc2;
    next_low_seen = is_start ? 1'b0 : (low_seen | ~sc2);
    next_busy = busy;
    if (is_start) begin
      next_busy = 1'b1;
    end else if (is_stop) begin
      next_busy = 1'b0;
    end
    next_rsda = is_rise ? sd2 : rsda;
    next_pend = is_rise;
    next_start_t = start_t ^ is_start;
    next_stop_t = stop_t ^ is_stop;
    next_fall_t = fall_t ^ is_fall;
    next_rise_t = rise_t ^ pend;                   // Data settles a cycle ahead
  end

  // Registers
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      sc1 <= 1'b1;
      sc2 <= 1'b1;
      sd1 <= 1'b1;
      sd2 <= 1'b1;
      scp <= 1'b1;
      sdp <= 1'b1;
      low_seen <= 1'b0;
      busy <= 1'b0;
      pend <= 1'b0;
      rsda <= 1'b1;
      start_t <= 1'b0;
      stop_t <= 1'b0;
      rise_t <= 1'b0;
      fall_t <= 1'b0;
    end else begin
      sc1 <= scl_in;
      sc2 <= sc1;
      sd1 <= sda_in;
      sd2 <= sd1;
      scp <= sc2;
      sdp <= sd2;
      low_seen <= next_low_seen;
      busy <= next_busy;
      pend <= next_pend;
      rsda <= next_rsda;
      start_t <= next_start_t;
      stop_t <= next_stop_t;
      rise_t <= next_rise_t;
      fall_t <= next_fall_t;
    end
  end

  assign cond.start_t = start_t;
  assign cond.stop_t = stop_t;
  assign cond.rise_t = rise_t;
  assign cond.fall_t = fall_t;
  assign cond.rise_sda = rsda;
  assign cond.busy = busy;
endmodule

// ===== logic/i2cbc_top.sv
// Two-wire bus master/slave condition, addressing and collision logic
`timescale 1ns/1ns
module i2cbc_top
  import i2cbc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic long_hold_select,
  input wire logic start_irq_enable,
  input wire logic stop_irq_enable,
  input wire logic native_cond_irq,
  input wire logic ten_bit_mode,
  input wire logic [9:0] own_slave_address,
  input wire logic cmd_valid,
  input wire i2cbc_op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  input wire logic collision_clear,
  input wire logic [7:0] tx_data,
  input wire logic tx_load,
  output logic master_busy,
  output logic master_owns,
  output logic master_done,
  output logic [7:0] master_data,
  output logic master_nack,
  output logic bus_active,
  output logic bus_collision,
  output logic start_irq,
  output logic stop_irq,
  output logic slave_addressed,
  output logic slave_reading,
  output logic tx_request,
  output logic [7:0] rx_data,
  output logic rx_valid
);

  // ----------------------------------------
  // Link-domain detector and crossings
  // ----------------------------------------
  i2cbc_cond_if cond ();
  logic scl_s, sda_s, busy_s, sda_r;
  logic ev_start, ev_stop, ev_rise, ev_fall;

  i2cbc_cond_det u_det (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .cond(cond)
  );

  i2cbc_evt_sync u_scl (.clk(mclk), .rst_n(rst_n), .din(scl_in), .level(scl_s), .pulse());
  i2cbc_evt_sync u_sda (.clk(mclk), .rst_n(rst_n), .din(sda_in), .level(sda_s), .pulse());
  i2cbc_evt_sync u_bsy (.clk(mclk), .rst_n(rst_n), .din(cond.busy), .level(busy_s), .pulse());
  i2cbc_evt_sync u_rsd (.clk(mclk), .rst_n(rst_n), .din(cond.rise_sda), .level(sda_r),
                        .pulse());
  i2cbc_evt_sync u_sta (.clk(mclk), .rst_n(rst_n), .din(cond.start_t), .level(),
                        .pulse(ev_start));
  i2cbc_evt_sync u_sto (.clk(mclk), .rst_n(rst_n), .din(cond.stop_t), .level(),
                        .pulse(ev_stop));
  i2cbc_evt_sync u_ris (.clk(mclk), .rst_n(rst_n), .din(cond.rise_t), .level(),
                        .pulse(ev_rise));
  i2cbc_evt_sync u_fal (.clk(mclk), .rst_n(rst_n), .din(cond.fall_t), .level(),
                        .pulse(ev_fall));

  // ----------------------------------------
  // Master engine
  // ----------------------------------------
  i2cbc_mst_e m_state, next_m_state;
  logic [11:0] m_cnt, next_m_cnt;
  logic [3:0] m_bit, next_m_bit;
  logic [7:0] m_sh, next_m_sh;
  logic m_rd, next_m_rd, m_ackv, next_m_ackv;
  logic m_scl_low, next_m_scl_low, m_sda_low, next_m_sda_low;
  logic m_own, next_m_own, next_m_done, m_nack, next_m_nack;
  logic m_coll, m_half, m_drive;

  // Master sequencing, clock generation and arbitration
  always_comb begin
    next_m_state = m_state;
    next_m_cnt = m_cnt + 12'h001;
    next_m_bit = m_bit;
    next_m_sh = m_sh;
    next_m_rd = m_rd;
    next_m_ackv = m_ackv;
    next_m_scl_low = m_scl_low;
    next_m_sda_low = m_sda_low;
    next_m_own = m_own;
    next_m_done = 1'b0;
    next_m_nack = m_nack;
    m_coll = 1'b0;
    m_half = (m_cnt == SCL_HALF_CYC - 12'h001);
    m_drive = m_bit[3] ? m_rd : ~m_rd;
    unique case (m_state)
      M_IDLE: begin
        next_m_cnt = 12'h000;
        if (cmd_valid) begin
          next_m_done = 1'b1;
          unique case (cmd_op)
            OP_START: begin
              if (busy_s && !m_own) begin
                m_coll = 1'b1;
              end else begin
                next_m_done = 1'b0;                    // Restart when owned
                next_m_state = M_START_A;
                next_m_sda_low = 1'b0;
              end
            end
            OP_STOP: begin
              if (m_own) begin
                next_m_done = 1'b0;
                next_m_state = M_STOP_A;
              end
            end
            default: begin
              if (m_own) begin
                next_m_done = 1'b0;
                next_m_state = M_LOW;
                next_m_rd = (cmd_op == OP_READ);
                next_m_sh = (cmd_op == OP_READ) ? 8'hFF : cmd_data;
                next_m_ackv = cmd_ack;
                next_m_bit = 4'h0;
              end else begin
                next_m_nack = 1'b1;
              end
            end
          endcase
        end
      end
      M_START_A: begin
        next_m_sda_low = 1'b0;
        if (sda_s) begin
          next_m_scl_low = 1'b0;
        end
        if (!(sda_s && scl_s)) begin
          next_m_cnt = 12'h000;
        end
        if (scl_s && !sda_s && !m_scl_low && m_cnt != 12'h000) begin
          m_coll = 1'b1;
        end else if (m_half) begin
          next_m_state = M_START_B;
          next_m_cnt = 12'h000;
          next_m_sda_low = 1'b1;
        end
      end
      M_START_B: begin
        if (m_half) begin
          next_m_scl_low = 1'b1;
          next_m_own = 1'b1;
          next_m_done = 1'b1;
          next_m_state = M_IDLE;
        end
      end
      M_LOW: begin
        next_m_scl_low = 1'b1;
        if (m_cnt == SYNC_LAT) begin
          next_m_sda_low = m_bit[3] ? (m_rd & m_ackv) : (~m_rd & ~m_sh[7]);
        end
        if (m_half) begin
          next_m_state = M_HIGH;
          next_m_cnt = 12'h000;
          next_m_scl_low = 1'b0;
        end
      end
      M_HIGH: begin
        if (!scl_s) begin
          next_m_cnt = 12'h000;
        end else if (m_half) begin
          next_m_cnt = 12'h000;
          next_m_scl_low = 1'b1;
          if (m_drive && !m_sda_low && !sda_s) begin
            m_coll = 1'b1;
          end else if (m_bit[3]) begin
            next_m_nack = m_rd ? 1'b0 : sda_s;
            next_m_done = 1'b1;
            next_m_state = M_IDLE;
          end else begin
            next_m_sh = {m_sh[6:0], sda_s};
            next_m_bit = m_bit + 4'h1;
            next_m_state = M_LOW;
          end
        end
      end
      M_STOP_A: begin
        if (m_cnt == SYNC_LAT) begin
          next_m_sda_low = 1'b1;
        end
        if (m_half) begin
          next_m_state = M_STOP_B;
          next_m_cnt = 12'h000;
        end
      end
      M_STOP_B: begin
        next_m_scl_low = 1'b0;
        if (!scl_s) begin
          next_m_cnt = 12'h000;
        end else if (m_half) begin
          next_m_state = M_STOP_C;
          next_m_cnt = 12'h000;
          next_m_sda_low = 1'b0;
        end
      end
      M_STOP_C: begin
        if (m_half) begin
          next_m_own = 1'b0;
          next_m_done = 1'b1;
          next_m_state = M_IDLE;
        end
      end
    endcase
    // Lost arbitration: let go of both lines at once
    if (m_coll && m_state != M_IDLE) begin
      next_m_state = M_IDLE;
      next_m_scl_low = 1'b0;
      next_m_sda_low = 1'b0;
      next_m_own = 1'b0;
      next_m_done = 1'b1;
    end
  end

  // Master registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      m_state <= M_IDLE;
      m_cnt <= 12'h000;
      m_bit <= 4'h0;
      m_sh <= 8'h00;
      m_rd <= 1'b0;
      m_ackv <= 1'b0;
      m_scl_low <= 1'b0;
      m_sda_low <= 1'b0;
      m_own <= 1'b0;
      master_done <= 1'b0;
      m_nack <= 1'b0;
      master_busy <= 1'b0;
    end else begin
      m_state <= next_m_state;
      m_cnt <= next_m_cnt;
      m_bit <= next_m_bit;
      m_sh <= next_m_sh;
      m_rd <= next_m_rd;
      m_ackv <= next_m_ackv;
      m_scl_low <= next_m_scl_low;
      m_sda_low <= next_m_sda_low;
      m_own <= next_m_own;
      master_done <= next_m_done;
      m_nack <= next_m_nack;
      master_busy <= (next_m_state != M_IDLE);
    end
  end

  assign master_owns = m_own;
  assign master_data = m_sh;
  assign master_nack = m_nack;

  // ----------------------------------------
  // Slave engine
  // ----------------------------------------
  i2cbc_slv_e s_state, next_s_state;
  logic [3:0] s_bit, next_s_bit;
  logic [7:0] s_sh, next_s_sh, next_rx_data;
  logic [1:0] s_ph, next_s_ph;
  logic s_rw, next_s_rw, s_match, next_s_match, s_ten, next_s_ten;
  logic s_sda_low, next_s_sda_low, s_scl_low, next_s_scl_low;
  logic next_tx_req, next_rx_valid, s_coll, pre_hit;

  // Address compare, receive, transmit and stretching
  always_comb begin
    next_s_state = s_state;
    next_s_bit = s_bit;
    next_s_sh = s_sh;
    next_s_ph = s_ph;
    next_s_rw = s_rw;
    next_s_match = s_match;
    next_s_ten = s_ten;
    next_s_sda_low = s_sda_low;
    next_s_scl_low = s_scl_low;
    next_tx_req = tx_request;
    next_rx_valid = 1'b0;
    next_rx_data = rx_data;
    s_coll = 1'b0;
    pre_hit = (s_sh[7:3] == TEN_BIT_PREFIX) && (s_sh[2:1] == own_slave_address[9:8]);
    if (ev_stop) begin
      next_s_state = S_IDLE;
      next_s_ten = 1'b0;
      next_s_match = 1'b0;
      next_s_rw = 1'b0;
      next_s_sda_low = 1'b0;
      next_s_scl_low = 1'b0;
      next_tx_req = 1'b0;
    end else if (ev_start) begin
      // Our own Start or Restart leaves the slave idle
      next_s_state = (m_own || m_state != M_IDLE) ? S_IDLE : S_RECV;
      next_s_bit = 4'h0;
      next_s_ph = PH_ADDR;
      next_s_match = 1'b0;
      next_s_rw = 1'b0;
      next_s_sda_low = 1'b0;
      next_s_scl_low = 1'b0;
      next_tx_req = 1'b0;
    end else begin
      unique case (s_state)
        S_IDLE: begin
        end
        S_RECV: begin
          if (ev_rise && s_bit != LAST_BIT) begin
            next_s_sh = {s_sh[6:0], sda_r};
            next_s_bit = s_bit + 4'h1;
          end else if (ev_fall && s_bit == ACK_BIT) begin
            next_s_sda_low = 1'b1;
            if (s_ph == PH_DATA) begin
              next_rx_data = s_sh;
              next_rx_valid = 1'b1;
            end else if (s_ph == PH_ADDR_LO) begin
              next_s_ph = PH_DATA;
              next_s_match = (s_sh == own_slave_address[7:0]);
              next_s_ten = next_s_match;
            end else if (ten_bit_mode && pre_hit && !s_sh[0]) begin
              next_s_ph = PH_ADDR_LO;
            end else if (ten_bit_mode) begin
              next_s_match = pre_hit && s_sh[0] && s_ten;
              next_s_rw = 1'b1;
              next_s_ph = PH_DATA;
            end else begin
              next_s_match = (s_sh[7:1] == own_slave_address[6:0]);
              next_s_rw = s_sh[0];
              next_s_ph = PH_DATA;
            end
            if (s_ph != PH_DATA && !next_s_match && next_s_ph != PH_ADDR_LO) begin
              next_s_sda_low = 1'b0;
              next_s_state = S_IDLE;
            end
          end else if (ev_fall && s_bit == LAST_BIT) begin
            next_s_bit = 4'h0;
            next_s_sda_low = 1'b0;
            if (s_match && s_rw) begin
              next_s_state = S_WAIT;
              next_s_scl_low = 1'b1;
              next_tx_req = 1'b1;
            end
          end
        end
        S_TX: begin
          if (ev_rise) begin
            next_s_bit = s_bit + 4'h1;
            if (s_bit < ACK_BIT && !s_sda_low && !sda_r) begin
              s_coll = 1'b1;
            end
            if (s_bit == ACK_BIT && sda_r) begin
              next_s_state = S_IDLE;
              next_s_bit = 4'h0;
            end
          end else if (ev_fall) begin
            if (s_bit == ACK_BIT) begin
              next_s_sda_low = 1'b0;
            end else if (s_bit == LAST_BIT) begin
              next_s_bit = 4'h0;
              next_s_state = S_WAIT;
              next_s_scl_low = 1'b1;
              next_tx_req = 1'b1;
            end else begin
              next_s_sh = {s_sh[6:0], 1'b0};
              next_s_sda_low = ~s_sh[6];
            end
          end
        end
        S_WAIT: begin
          if (tx_request && tx_load) begin
            next_s_sh = tx_data;
            next_s_sda_low = ~tx_data[7];
            next_tx_req = 1'b0;
          end else if (!tx_request) begin
            next_s_scl_low = 1'b0;
            next_s_state = S_TX;
          end
        end
      endcase
    end
  end

  // Slave registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_state <= S_IDLE;
      s_bit <= 4'h0;
      s_sh <= 8'h00;
      s_ph <= PH_ADDR;
      s_rw <= 1'b0;
      s_match <= 1'b0;
      s_ten <= 1'b0;
      s_sda_low <= 1'b0;
      s_scl_low <= 1'b0;
      tx_request <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      s_state <= next_s_state;
      s_bit <= next_s_bit;
      s_sh <= next_s_sh;
      s_ph <= next_s_ph;
      s_rw <= next_s_rw;
      s_match <= next_s_match;
      s_ten <= next_s_ten;
      s_sda_low <= next_s_sda_low;
      s_scl_low <= next_s_scl_low;
      tx_request <= next_tx_req;
      rx_valid <= next_rx_valid;
      rx_data <= next_rx_data;
    end
  end

  assign slave_addressed = s_match;
  assign slave_reading = s_rw;

  // ----------------------------------------
  // Pins, hold timing and status
  // ----------------------------------------
  logic [3:0] hold_cnt, next_hold_cnt;
  logic scl_d, next_sda_oe, next_coll, next_start_irq, next_stop_irq;

  // SDA changes only after hold time following an SCL fall
  always_comb begin
    next_hold_cnt = (hold_cnt != 4'h0) ? hold_cnt - 4'h1 : 4'h0;
    if (scl_d && !scl_s) begin
      next_hold_cnt = long_hold_select ? LONG_HOLD_CYC : SHORT_HOLD_CYC;
    end
    next_sda_oe = (hold_cnt == 4'h0) ? (m_sda_low | s_sda_low) : sda_oe;
    next_coll = (bus_collision & ~collision_clear) | m_coll | s_coll;
    next_start_irq = ev_start & (native_cond_irq | start_irq_enable);
    next_stop_irq = ev_stop & (native_cond_irq | stop_irq_enable);
  end

  // Pin and status registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 4'h0;
      scl_d <= 1'b0;                                   // Matches synchroniser reset, no false fall
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      bus_collision <= 1'b0;
      bus_active <= 1'b0;
      start_irq <= 1'b0;
      stop_irq <= 1'b0;
    end else begin
      hold_cnt <= next_hold_cnt;
      scl_d <= scl_s;
      sda_oe <= next_sda_oe;
      scl_oe <= m_scl_low | s_scl_low;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      bus_collision <= next_coll;
      bus_active <= busy_s;
      start_irq <= next_start_irq;
      stop_irq <= next_stop_irq;
    end
  end
endmodule

// ===== verif/i2cbc_asserts.sv
// Port-level checks for the bus-condition block
`timescale 1ns/1ns
module i2cbc_asserts
  import i2cbc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic long_hold_select,
  input wire logic start_irq_enable,
  input wire logic stop_irq_enable,
  input wire logic native_cond_irq,
  input wire logic cmd_valid,
  input wire i2cbc_op_e cmd_op,
  input wire logic collision_clear,
  input wire logic master_busy,
  input wire logic master_owns,
  input wire logic master_done,
  input wire logic master_nack,
  input wire logic bus_active,
  input wire logic bus_collision,
  input wire logic start_irq,
  input wire logic stop_irq,
  input wire logic rx_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Our own SCL fall, then SDA frozen through the long hold
  sequence s_fall;
    $rose(scl_oe) && master_owns && long_hold_select;
  endsequence
  sequence s_hold;
    $stable(sda_oe) [*5];
  endsequence
  logic idle_cmd;
  assign idle_cmd = cmd_valid && !master_busy && !master_owns;
  a_sda_hold_long: assert property (s_fall |=> s_hold) else $error("sda moved in hold");
  a_start_irq_gate: assert property (start_irq |-> start_irq_enable || native_cond_irq)
    else $error("start irq without enable");
  a_stop_irq_gate: assert property (stop_irq |-> stop_irq_enable || native_cond_irq)
    else $error("stop irq without enable");
  a_done_one_cycle: assert property (master_done |=> !master_done) else $error("done too long");
  a_rx_one_cycle: assert property (rx_valid |=> !rx_valid) else $error("rx pulse too long");
  a_collision_sticky: assert property (bus_collision && !collision_clear |=> bus_collision)
    else $error("collision flag lost");
  a_refused_write: assert property (idle_cmd && cmd_op == OP_WRITE |-> ##[1:2] master_done && master_nack)
    else $error("write without bus not refused");
  a_start_collides: assert property (idle_cmd && cmd_op == OP_START && bus_active |-> ##[1:3] bus_collision)
    else $error("start on busy bus not flagged");
endmodule
bind i2cbc_top i2cbc_asserts i2cbc_asserts_i (.*);

// ===== verif/i2cbc_peer.sv
// Far-side slave that acknowledges or refuses each byte
`timescale 1ns/1ns
module i2cbc_peer (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  output logic sda_pull
);
  int n = 0;
  initial sda_pull = 1'b0;
  // Restart the fall count at each Start
  always @(negedge sda) if (scl) n = 0;
  // Pull SDA in the ninth bit, changed well after the fall
  always @(negedge scl) begin
    n = n + 1;
    #400 sda_pull = !nack && n > 0 && n % 9 == 0;
  end
endmodule

// ===== verif/i2c_bus_condition_logic_tb.sv
// Self-checking bench for the bus-condition block
`timescale 1ns/1ns
module i2c_bus_condition_logic_tb;
  import i2cbc_pkg::*;
  logic mclk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, b_scl = 1'b0, b_sda = 1'b0, p_nack = 1'b0;
  logic long_hold_select = 1'b1, start_irq_enable = 1'b0, stop_irq_enable = 1'b0;
  logic native_cond_irq = 1'b0, ten_bit_mode = 1'b0, cmd_valid = 1'b0, cmd_ack = 1'b0;
  logic collision_clear = 1'b0, tx_load = 1'b0, p_sda;
  logic [9:0] own_slave_address = 10'h05A;
  logic [7:0] cmd_data = 8'h00, tx_data = 8'h00, master_data, rx_data, rx_seen = 8'h00;
  i2cbc_op_e cmd_op = OP_START;
  logic scl_out, scl_oe, sda_out, sda_oe, master_busy, master_owns, master_done, master_nack;
  logic bus_active, bus_collision, start_irq, stop_irq, slave_addressed, slave_reading;
  logic tx_request, rx_valid;
  int n_tests = 0, miscompares = 0, n_start = 0, n_stop = 0;
  wire scl_in = !(scl_oe | b_scl);
  wire sda_in = !(sda_oe | b_sda | p_sda);
  i2cbc_top i2cbc_top_i (.*);
  i2cbc_peer i2cbc_peer_i (.scl(scl_in), .sda(sda_in), .nack(p_nack), .sda_pull(p_sda));
  // Clocks of both domains
  always #25 mclk = !mclk;
  always #24 link_clk = !link_clk;
  // Event counters and received byte
  always @(posedge mclk) begin
    n_start <= n_start + (start_irq === 1'b1);
    n_stop <= n_stop + (stop_irq === 1'b1);
    if (rx_valid === 1'b1) rx_seen <= rx_data;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cmd(input i2cbc_op_e op, input logic [7:0] d);
    int i;
    cmd_op <= op;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 4000 && master_done !== 1'b1; i++) @(negedge mclk);
    chk("done", 8'h01, master_done);
    chk("busy", 8'h00, master_busy);
    chk("pins low", 8'h00, {sda_out, scl_out});
    @(posedge mclk);
  endtask
  // Bench as bus master: pull flags for SDA and SCL
  task automatic ln(input logic d, input logic c);
    b_sda <= d;
    b_scl <= c;
    wt(20);
  endtask
  task automatic put(input logic [7:0] d, output logic a);
    int i;
    for (i = 8; i >= 0; i--) begin
      ln(b_sda, 1'b1);
      ln(i > 0 ? !d[i - 1] : 1'b0, 1'b1);
      ln(b_sda, 1'b0);
    end
    a = sda_in;
  endtask
  task automatic stop;
    ln(b_sda, 1'b1);
    ln(1'b1, 1'b1);
    ln(1'b1, 1'b0);
    ln(1'b0, 1'b0);
  endtask
  task automatic t_master;
    cmd(OP_WRITE, 8'h33);
    chk("refused nack", 8'h01, master_nack);
    cmd(OP_START, 8'h00);
    chk("owns", 8'h01, master_owns);
    chk("active", 8'h01, bus_active);
    cmd(OP_WRITE, 8'h5A);
    chk("ack", 8'h00, master_nack);
    chk("wdata", 8'h5A, master_data);
    p_nack <= 1'b1;
    cmd(OP_WRITE, 8'hC3);
    chk("nack", 8'h01, master_nack);
    long_hold_select <= 1'b0;
    cmd(OP_READ, 8'h00);
    chk("rdata", 8'hFF, master_data);
    cmd(OP_STOP, 8'h00);
    chk("owns", 8'h00, master_owns);
    chk("idle", 8'h00, bus_active);
  endtask
  task automatic t_slave(input logic [6:0] ad, input logic hit);
    logic a;
    int s0, p0;
    s0 = n_start;
    p0 = n_stop;
    start_irq_enable <= hit;
    stop_irq_enable <= hit;
    ln(1'b1, 1'b0);
    put({ad, 1'b0}, a);
    chk("addr ack", !hit, a);
    chk("addressed", hit, slave_addressed);
    if (hit) begin
      put(8'hA5, a);
      chk("rx", 8'hA5, rx_seen);
    end
    stop;
    chk("starts", hit, n_start - s0);
    chk("stops", hit, n_stop - p0);
  endtask
  task automatic t_ten;
    logic a;
    logic [7:0] d;
    int i;
    ten_bit_mode <= 1'b1;
    ln(1'b1, 1'b0);
    put(8'hF0, a);
    put(8'h5A, a);
    chk("ten match", 8'h01, slave_addressed);
    ln(1'b0, 1'b1);
    ln(1'b0, 1'b0);
    ln(1'b1, 1'b0);
    put(8'hF1, a);
    chk("ten read ack", 8'h00, a);
    ln(1'b0, 1'b1);
    chk("tx request", 8'h01, tx_request);
    ln(1'b0, 1'b0);
    chk("stretch", 8'h00, scl_in);
    tx_data <= 8'hC6;
    tx_load <= 1'b1;
    wt(1);
    tx_load <= 1'b0;
    for (i = 7; i >= 0; i--) begin
      if (i < 7) ln(1'b0, 1'b1);
      ln(1'b0, 1'b0);
      d[i] = sda_in;
    end
    chk("tx byte", 8'hC6, d);
    chk("reading", 8'h01, slave_reading);
    ln(1'b0, 1'b1);
    ln(1'b0, 1'b0);
    stop;
  endtask
  task automatic t_glitch;
    int s0, p0;
    s0 = n_start;
    p0 = n_stop;
    start_irq_enable <= 1'b0;
    stop_irq_enable <= 1'b0;
    native_cond_irq <= 1'b1;
    ln(1'b1, 1'b0);
    ln(1'b0, 1'b0);
    chk("glitch starts", 8'h01, n_start - s0);
    chk("glitch stops", 8'h00, n_stop - p0);
    cmd(OP_START, 8'h00);
    chk("collision", 8'h01, bus_collision);
    collision_clear <= 1'b1;
    wt(1);
    collision_clear <= 1'b0;
    wt(2);
    chk("cleared", 8'h00, bus_collision);
    stop;
    chk("stop idle", 8'h00, bus_active);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    wt(20);
    rst_n <= 1'b1;
    wt(6);
    t_master();
    t_slave(7'h5A, 1'b1);
    t_slave(7'h5B, 1'b0);
    t_ten();
    t_glitch();
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #3000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
